/* File: dit_consts.svh */
// timing constants for the instruction sequencer
`ifndef DIT_CONSTS_SVH
`define DIT_CONSTS_SVH
`define DIT_CLK_PER_CYC 2
`define DIT_REP_LIMIT 16'h0200
`define DIT_OP_W 6
`define DIT_CNT_W 3
`endif

/* File: dit_pkg.sv */
// types for the instruction sequencer
`include "dit_consts.svh"
package dit_pkg;
  typedef enum logic [5:0] {
    DIT_ASG_IND_SINGLE = 6'h00,
    DIT_ASG_IND_DOUBLE = 6'h01,
    DIT_ASG_DIRECT = 6'h02,
    DIT_ASG_IND_INDEXED = 6'h03,
    DIT_ASG_IMM_SHORT = 6'h04,
    DIT_ASG_IMM_LONG = 6'h05,
    DIT_ASG_REG_REG = 6'h06,
    DIT_ASG_PROGRAM_MEMORY = 6'h07,
    DIT_ALU = 6'h08,
    DIT_PLAIN_MULTIPLY = 6'h09,
    DIT_DOUBLE_PRECISION_MULTIPLY = 6'h0A,
    DIT_ALU_PLAIN_MULTIPLY = 6'h0B,
    DIT_SQUARE_OP = 6'h0C,
    DIT_BIT_TEST_HIGH = 6'h0D,
    DIT_BIT_TEST_LOW = 6'h0E,
    DIT_BIT_TEST_HIGH_SET = 6'h0F,
    DIT_BIT_TEST_LOW_CLEAR = 6'h10,
    DIT_FLOW = 6'h11,
    DIT_FLOW_DELAYED = 6'h12,
    DIT_CONDITIONAL_LOAD = 6'h13,
    DIT_REPEAT_SINGLE = 6'h14,
    DIT_REPEAT_BLOCK = 6'h15,
    DIT_LSP_INC = 6'h16,
    DIT_LSP_DEC = 6'h17,
    DIT_COPROC_SINGLE_MOVE = 6'h18,
    DIT_COPROC_DOUBLE_MOVE = 6'h19,
    DIT_PUSH_POP_REG = 6'h1A,
    DIT_DOUBLE_PUSH_POP_REG = 6'h1B,
    DIT_PUSH_POP_DIRECT = 6'h1C,
    DIT_PUSH_IMM = 6'h1D,
    DIT_STACK_INDEXED = 6'h1E,
    DIT_INC_SP = 6'h1F
  } dit_op_t;

  // decoded instruction offered by the decoder
  typedef struct packed {
    dit_op_t op;
    logic long_form;
    logic [15:0] rep_count;
    logic [1:0] ptr_sel;
    logic [1:0] idx_sel;
  } dit_instr_t;

  // timing of one instruction
  typedef struct packed {
    logic [2:0] words;
    logic [2:0] cycles;
  } dit_cost_t;
endpackage

/* File: dit_cost.sv */
// words and cycles lookup per instruction group
`timescale 1ns/1ps
`include "dit_consts.svh"
module dit_cost (
  // decoded instruction
  input wire dit_pkg::dit_instr_t instr,
  // resulting cost
  output dit_pkg::dit_cost_t cost
);
  always_comb
  begin
    cost = '{words: 3'h1, cycles: 3'h1};
    unique case (instr.op)
      dit_pkg::DIT_ASG_DIRECT, dit_pkg::DIT_ASG_IMM_LONG:
        cost = '{words: 3'h2, cycles: 3'h2};
      dit_pkg::DIT_ASG_IND_INDEXED:
        cost = '{words: 3'h1, cycles: 3'h2};
      dit_pkg::DIT_ASG_PROGRAM_MEMORY:
        cost = '{words: 3'h1, cycles: 3'h4};
      dit_pkg::DIT_DOUBLE_PRECISION_MULTIPLY:
        cost = '{words: 3'h1, cycles: 3'h2};
      dit_pkg::DIT_BIT_TEST_HIGH, dit_pkg::DIT_BIT_TEST_LOW,
      dit_pkg::DIT_BIT_TEST_HIGH_SET, dit_pkg::DIT_BIT_TEST_LOW_CLEAR:
        cost = '{words: 3'h2, cycles: 3'h2};
      dit_pkg::DIT_FLOW:
        cost = '{words: 3'h1, cycles: instr.long_form ? 3'h3 : 3'h2};
      dit_pkg::DIT_FLOW_DELAYED:
        cost = '{words: 3'h1, cycles: instr.long_form ? 3'h2 : 3'h1};
      dit_pkg::DIT_CONDITIONAL_LOAD:
        cost = '{words: 3'h1, cycles: 3'h2};
      dit_pkg::DIT_REPEAT_SINGLE:
        if (instr.rep_count >= `DIT_REP_LIMIT)
          cost = '{words: 3'h2, cycles: 3'h2};
      dit_pkg::DIT_REPEAT_BLOCK:
        if (instr.rep_count >= `DIT_REP_LIMIT && instr.long_form)
          cost = '{words: 3'h3, cycles: 3'h3};
        else
          cost = '{words: 3'h2, cycles: 3'h2};
      dit_pkg::DIT_PUSH_POP_DIRECT, dit_pkg::DIT_PUSH_IMM:
        cost = '{words: 3'h2, cycles: 3'h3};
      dit_pkg::DIT_STACK_INDEXED:
        cost = '{words: 3'h1, cycles: 3'h2};
      default:
        cost = '{words: 3'h1, cycles: 3'h1};
    endcase
  end
endmodule

/* File: dit_seq.sv */
// instruction sequencer: pipeline timing and co-processor strobe
`timescale 1ns/1ps
`include "dit_consts.svh"
module dit_seq (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // decoder side
  input wire logic instr_valid,
  input wire dit_pkg::dit_instr_t instr,
  output logic instr_ready,
  // program memory fetch
  output logic fetch_strobe,
  // execute side
  output logic cycle_enable,
  output logic exec_start,
  output logic exec_busy,
  output logic [1:0] coproc_transfers,
  output logic index_error,
  output logic [1:0] loop_stack_pointer,
  // co-processor
  output logic coproc_instr_valid
);
  typedef enum logic [1:0] {
    DIT_IDLE = 2'b00,
    DIT_FETCH = 2'b01,
    DIT_EXEC = 2'b10,
    DIT_DECODE = 2'b11
  } dit_state_t;

  dit_pkg::dit_cost_t cost;
  dit_state_t state_reg, state_next;
  logic phase_reg, phase_next;
  logic [2:0] words_reg, words_next;
  logic [2:0] cycles_reg, cycles_next;
  logic [1:0] lsp_reg, lsp_next;
  logic cop_reg, cop_next;
  logic [1:0] xfer_reg, xfer_next;
  logic idx_err_reg, idx_err_next;
  logic start_reg, start_next;
  logic fetch_reg, fetch_next;

  dit_cost u_cost (
    .instr(instr),
    .cost(cost)
  );

  // allowed post-increment index belongs to the pointer's pair
  function automatic logic index_ok(input logic [1:0] ptr, input logic [1:0] idx);
    index_ok = (idx[1] == ptr[0]);
  endfunction

  // cycle enable: one instruction cycle per two input clocks
  always_comb
  begin
    phase_next = ~phase_reg;
  end

  assign cycle_enable = phase_reg;
  assign instr_ready = (state_reg == DIT_IDLE) && cycle_enable;

  always_comb
  begin
    state_next = state_reg;
    words_next = words_reg;
    cycles_next = cycles_reg;
    lsp_next = lsp_reg;
    // strobe held for the whole two-clock decode cycle
    cop_next = cop_reg & ~cycle_enable;
    xfer_next = xfer_reg;
    idx_err_next = idx_err_reg;
    start_next = 1'b0;
    fetch_next = 1'b0;
    if (cycle_enable)
    begin
      unique case (state_reg)
        DIT_IDLE:
          if (instr_valid)
          begin
            fetch_next = 1'b1;
            words_next = cost.words - 3'h1;
            cycles_next = cost.cycles;
            state_next = DIT_FETCH;
            if (instr.op == dit_pkg::DIT_COPROC_DOUBLE_MOVE)
            begin
              xfer_next = 2'h2;
              idx_err_next = ~index_ok(instr.ptr_sel, instr.idx_sel);
            end
            else if (instr.op == dit_pkg::DIT_COPROC_SINGLE_MOVE)
            begin
              xfer_next = 2'h1;
              idx_err_next = 1'b0;
            end
            else
            begin
              xfer_next = 2'h0;
              idx_err_next = 1'b0;
            end
            if (instr.op == dit_pkg::DIT_LSP_INC)
              lsp_next = lsp_reg + 2'h1;
            else if (instr.op == dit_pkg::DIT_LSP_DEC)
              lsp_next = lsp_reg - 2'h1;
          end
        DIT_FETCH:
        begin
          // first word in; an extension word follows in the decode cycle
          if (words_reg != 3'h0)
          begin
            fetch_next = 1'b1;
            words_next = words_reg - 3'h1;
          end
          // strobe covers the decode cycle of a co-processor move
          if (xfer_reg != 2'h0)
            cop_next = 1'b1;
          state_next = DIT_DECODE;
        end
        DIT_DECODE:
        begin
          // last extension word, execute two cycles after first fetch
          if (words_reg != 3'h0)
          begin
            fetch_next = 1'b1;
            words_next = words_reg - 3'h1;
          end
          start_next = 1'b1;
          state_next = DIT_EXEC;
        end
        DIT_EXEC:
        begin
          cycles_next = cycles_reg - 3'h1;
          if (cycles_reg == 3'h1)
            state_next = DIT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= DIT_IDLE;
      phase_reg <= 1'b0;
      words_reg <= 3'h0;
      cycles_reg <= 3'h0;
      lsp_reg <= 2'h0;
      cop_reg <= 1'b0;
      xfer_reg <= 2'h0;
      idx_err_reg <= 1'b0;
      start_reg <= 1'b0;
      fetch_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      words_reg <= words_next;
      cycles_reg <= cycles_next;
      lsp_reg <= lsp_next;
      cop_reg <= cop_next;
      xfer_reg <= xfer_next;
      idx_err_reg <= idx_err_next;
      start_reg <= start_next;
      fetch_reg <= fetch_next;
    end
  end

  assign fetch_strobe = fetch_reg;
  assign exec_start = start_reg;
  assign exec_busy = (state_reg == DIT_EXEC);
  assign coproc_transfers = xfer_reg;
  assign index_error = idx_err_reg;
  assign loop_stack_pointer = lsp_reg;
  assign coproc_instr_valid = cop_reg;

  property p_cop_strobe;
    @(posedge clk) disable iff (rst)
    (cycle_enable && state_reg == DIT_IDLE && instr_valid &&
     instr.op == dit_pkg::DIT_COPROC_DOUBLE_MOVE)
      |=> !coproc_instr_valid [*2] ##1 coproc_instr_valid [*2] ##1 !coproc_instr_valid;
  endproperty
  a_cop_strobe: assert property (p_cop_strobe) else $error("strobe missing");

  property p_cop_exec;
    @(posedge clk) disable iff (rst)
    $rose(coproc_instr_valid) |-> ##2 exec_start;
  endproperty
  a_cop_exec: assert property (p_cop_exec) else $error("no execute after strobe");

  property p_xfer;
    @(posedge clk) disable iff (rst)
    $rose(coproc_instr_valid) |-> coproc_transfers != 2'h0;
  endproperty
  a_xfer: assert property (p_xfer) else $error("bad transfer count");

  property p_phase;
    @(posedge clk) disable iff (rst)
    cycle_enable |=> !cycle_enable ##1 cycle_enable;
  endproperty
  a_phase: assert property (p_phase) else $error("cycle enable rate wrong");

  property p_lsp;
    @(posedge clk) disable iff (rst)
    (instr_ready && instr_valid && instr.op == dit_pkg::DIT_LSP_INC)
      |=> loop_stack_pointer == $past(loop_stack_pointer) + 2'h1;
  endproperty
  a_lsp: assert property (p_lsp) else $error("loop stack pointer not incremented");

  property p_pmem;
    @(posedge clk) disable iff (rst)
    (instr_ready && instr_valid && instr.op == dit_pkg::DIT_ASG_PROGRAM_MEMORY)
      |-> ##5 exec_start ##0 exec_busy [*8] ##1 !exec_busy;
  endproperty
  a_pmem: assert property (p_pmem) else $error("program memory move length wrong");

  sequence s_two_fetch;
    fetch_strobe ##2 fetch_strobe;
  endsequence
  property p_bittest;
    @(posedge clk) disable iff (rst)
    (instr_ready && instr_valid && instr.op == dit_pkg::DIT_BIT_TEST_HIGH) |=> s_two_fetch;
  endproperty
  a_bittest: assert property (p_bittest) else $error("mask word not fetched");

  property p_idx;
    @(posedge clk) disable iff (rst)
    (instr_ready && instr_valid && instr.op == dit_pkg::DIT_COPROC_DOUBLE_MOVE &&
     instr.ptr_sel == 2'h1 && instr.idx_sel == 2'h0) |=> index_error;
  endproperty
  a_idx: assert property (p_idx) else $error("illegal index accepted");

  property p_conditional_load;
    @(posedge clk) disable iff (rst)
    (instr_ready && instr_valid && instr.op == dit_pkg::DIT_CONDITIONAL_LOAD)
      |-> ##5 exec_start ##0 exec_busy [*4] ##1 !exec_busy;
  endproperty
  a_conditional_load: assert property (p_conditional_load) else $error("conditional load length wrong");
endmodule

/* File: dit_coproc_model.sv */
// co-processor stand-in that watches the decode strobe
`timescale 1ns/1ps
module dit_coproc_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core side
  input wire logic coproc_instr_valid,
  // observed activity
  output logic [7:0] strobe_cnt,
  output logic [2:0] strobe_len
);
  logic [2:0] hi_cnt;
  logic [15:0] ctrl_reg;
  logic [15:0] status_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strobe_cnt <= 8'h00;
      strobe_len <= 3'h0;
      hi_cnt <= 3'h0;
      ctrl_reg <= 16'h0000;
      status_reg <= 16'h0000;
    end
    else if (coproc_instr_valid)
      hi_cnt <= hi_cnt + 3'h1;
    else if (hi_cnt != 3'h0)
    begin
      // strobe over: transfer lands in this execute cycle
      strobe_cnt <= strobe_cnt + 8'h01;
      strobe_len <= hi_cnt;
      hi_cnt <= 3'h0;
      status_reg <= status_reg + 16'h0001;
    end
  end
endmodule

/* File: dsp_instruction_timing_bench.sv */
// self-checking bench for the instruction sequencer
`timescale 1ns/1ps
module dsp_instruction_timing_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  dit_pkg::dit_instr_t instr = '0;
  logic instr_ready, fetch_strobe, cycle_enable, exec_start, exec_busy;
  logic index_error, coproc_instr_valid;
  logic [1:0] coproc_transfers, loop_stack_pointer;
  logic [7:0] strobe_cnt;
  logic [2:0] strobe_len;
  logic [7:0] ncop = 8'h00;
  int miscompares = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  dit_seq u_dit_seq (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .fetch_strobe(fetch_strobe), .cycle_enable(cycle_enable),
    .exec_start(exec_start), .exec_busy(exec_busy), .coproc_transfers(coproc_transfers),
    .index_error(index_error), .loop_stack_pointer(loop_stack_pointer),
    .coproc_instr_valid(coproc_instr_valid));
  dit_coproc_model u_dit_coproc_model (.clk(clk), .rst(rst),
    .coproc_instr_valid(coproc_instr_valid), .strobe_cnt(strobe_cnt),
    .strobe_len(strobe_len));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    begin
      checked++;
      if (got !== exp)
      begin
        miscompares++;
        $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  // issue one instruction; w of zero skips the word and cycle counts
  task automatic go(input dit_pkg::dit_op_t op, input logic lf, input logic [15:0] repeat_loop,
    input logic [2:0] w, input logic [2:0] c);
    int n;
    int f;
    int b;
    int s;
    int tf;
    int ts;
    int ce;
    begin
      n = 0;
      f = 0;
      b = 0;
      s = 0;
      tf = 0;
      ts = 0;
      ce = 0;
      while (instr_ready !== 1'b1 && n < 40)
      begin
        @(negedge clk);
        n++;
      end
      chk("ready", 8'h01, {7'h00, instr_ready});
      instr.op = op;
      instr.long_form = lf;
      instr.rep_count = repeat_loop;
      instr_valid = 1'b1;
      for (n = 1; n < 25; n++)
      begin
        @(negedge clk);
        instr_valid = 1'b0;
        if (fetch_strobe === 1'b1 && tf == 0)
          tf = n;
        if (fetch_strobe === 1'b1)
          f++;
        if (exec_start === 1'b1)
          ts = n;
        if (exec_start === 1'b1)
          s++;
        if (exec_busy === 1'b1)
          b++;
        if (cycle_enable === 1'b1)
          ce++;
      end
      chk("cycle_enable_count", 8'h0C, ce[7:0]);
      if (w != 3'h0)
      begin
        chk("words", {5'h00, w}, f[7:0]);
        chk("busy_clocks", {4'h0, c, 1'b0}, b[7:0]);
        chk("exec_start_pulses", 8'h01, s[7:0]);
      end
      if (w != 3'h0)
        chk("start_after_fetch", 8'h04, 8'(ts - tf));
    end
  endtask
  task automatic t_assign;
    logic [2:0] aw [8];
    logic [2:0] ac [8];
    begin
      aw = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h1, 3'h2, 3'h1, 3'h1};
      ac = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h2, 3'h1, 3'h4};
      for (int i = 0; i < 8; i++)
        go(dit_pkg::dit_op_t'(i), 1'b0, 16'h0000, aw[i], ac[i]);
      $display("test assign done");
    end
  endtask
  task automatic t_plain_multiply_bits;
    logic [2:0] aw [8];
    logic [2:0] ac [8];
    begin
      aw = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2};
      ac = '{3'h1, 3'h2, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2};
      for (int i = 0; i < 8; i++)
        go(dit_pkg::dit_op_t'(i + 9), 1'b0, 16'h0000, aw[i], ac[i]);
      go(dit_pkg::DIT_ALU, 1'b0, 16'h0000, 3'h1, 3'h1);
      $display("test multiply and bit done");
    end
  endtask
  task automatic t_flow_repeat;
    begin
      go(dit_pkg::DIT_FLOW, 1'b0, 16'h0000, 3'h1, 3'h2);
      go(dit_pkg::DIT_FLOW, 1'b1, 16'h0000, 3'h1, 3'h3);
      go(dit_pkg::DIT_FLOW_DELAYED, 1'b0, 16'h0000, 3'h1, 3'h1);
      go(dit_pkg::DIT_FLOW_DELAYED, 1'b1, 16'h0000, 3'h1, 3'h2);
      go(dit_pkg::DIT_CONDITIONAL_LOAD, 1'b0, 16'h0000, 3'h1, 3'h2);
      go(dit_pkg::DIT_REPEAT_SINGLE, 1'b0, 16'h01FF, 3'h1, 3'h1);
      go(dit_pkg::DIT_REPEAT_SINGLE, 1'b0, 16'h0200, 3'h2, 3'h2);
      go(dit_pkg::DIT_REPEAT_BLOCK, 1'b1, 16'h01FF, 3'h2, 3'h2);
      go(dit_pkg::DIT_REPEAT_BLOCK, 1'b0, 16'h0200, 3'h2, 3'h2);
      go(dit_pkg::DIT_REPEAT_BLOCK, 1'b1, 16'hFFFF, 3'h3, 3'h3);
      $display("test flow and repeat done");
    end
  endtask
  task automatic t_stack;
    logic [2:0] aw [6];
    logic [2:0] ac [6];
    begin
      aw = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h1};
      ac = '{3'h1, 3'h1, 3'h3, 3'h3, 3'h2, 3'h1};
      for (int i = 0; i < 6; i++)
        go(dit_pkg::dit_op_t'(i + 26), 1'b0, 16'h0000, aw[i], ac[i]);
      $display("test stack done");
    end
  endtask
  task automatic t_coproc;
    logic [1:0] ps [4];
    logic [1:0] is [4];
    logic er [4];
    begin
      ps = '{2'h0, 2'h1, 2'h1, 2'h3};
      is = '{2'h1, 2'h1, 2'h2, 2'h0};
      er = '{1'b0, 1'b1, 1'b0, 1'b1};
      go(dit_pkg::DIT_COPROC_SINGLE_MOVE, 1'b0, 16'h0000, 3'h1, 3'h1);
      ncop = ncop + 8'h01;
      chk("transfers", 8'h01, {6'h00, coproc_transfers});
      chk("strobe_len", 8'h02, {5'h00, strobe_len});
      for (int i = 0; i < 4; i++)
      begin
        instr.ptr_sel = ps[i];
        instr.idx_sel = is[i];
        go(dit_pkg::DIT_COPROC_DOUBLE_MOVE, 1'b0, 16'h0000, 3'h1, 3'h1);
        ncop = ncop + 8'h01;
        chk("transfers", 8'h02, {6'h00, coproc_transfers});
        chk("index_error", {7'h00, er[i]}, {7'h00, index_error});
        chk("strobe_cnt", ncop, strobe_cnt);
      end
      $display("test coprocessor done");
    end
  endtask
  task automatic t_lsp;
    logic [1:0] e;
    begin
      e = 2'h0;
      for (int i = 0; i < 5; i++)
      begin
        go(dit_pkg::DIT_LSP_INC, 1'b0, 16'h0000, 3'h1, 3'h1);
        e = e + 2'h1;
        chk("lsp_inc", {6'h00, e}, {6'h00, loop_stack_pointer});
      end
      go(dit_pkg::DIT_LSP_DEC, 1'b0, 16'h0000, 3'h1, 3'h1);
      chk("lsp_dec", {6'h00, e - 2'h1}, {6'h00, loop_stack_pointer});
      $display("test loop stack done");
    end
  endtask
  task automatic tally_and_finish;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    #30000;
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_assign();
    t_plain_multiply_bits();
    t_flow_repeat();
    t_stack();
    t_coproc();
    t_lsp();
    chk("strobe_total", ncop, strobe_cnt);
    tally_and_finish();
  end
endmodule
